/* ucqsc_defs.svh */
// Behaviour
// [RULE1] Queue status register is meaningful only in host mode; reads zero in device mode.
// [RULE2] Software accesses the queue status register only with full 32-bit word transfers.
// [RULE3] Top queue entry is a seven-bit field; its upper four bits hold the channel.
// [RULE4] Entry type code: 00 token, 01 zero-length OUT, 11 channel halt.
// [RULE5] Lowest entry bit flags the last queued request for its channel.
// [RULE6] Eight-bit free queue entry count, zero means full, ranges zero to eight.
// [RULE7] Sixteen-bit free FIFO word count, zero means full, never above configured depth.
// [RULE8] Queue status register resets to 0x00080200.
// [RULE9] Bus voltage ignore bit forces voltage valid and stops sensing the pin.
// [RULE10] A configuration bit enables the start-of-frame pulse output.
// [RULE11] Independent bits enable the B-side and A-side voltage comparators.
// [RULE12] A configuration bit switches embedded PHY power on.
// [RULE13] Configuration register resets to all zeros.
// [RULE14] Core identifier word is fully writable and readable by software.
// [RULE15] Software keeps the FIFO depth between 1 and 1024 words.
// [RULE16] Free counts drop on pushes and rise as the core consumes entries.
`ifndef UCQSC_DEFS_SVH
`define UCQSC_DEFS_SVH
`define UCQSC_OFF_QSTAT      8'h2C
`define UCQSC_OFF_CFG        8'h38
`define UCQSC_OFF_CID        8'h3C
`define UCQSC_QSTAT_RESET    32'h0008_0200
`define UCQSC_CFG_RESET      32'h0000_0000
`define UCQSC_CID_RESET      32'h5A5A_0001 // Arbitrary value
`define UCQSC_CFG_MASK       32'h003D_0000
`define UCQSC_BIT_VBUSIGN    21
`define UCQSC_BIT_FRAMEOUT   20
`define UCQSC_BIT_BCOMP      19
`define UCQSC_BIT_ACOMP      18
`define UCQSC_BIT_PHYPWR     16
`define UCQSC_QUEUE_DEPTH    8'h08
`define UCQSC_FIFO_DEPTH     16'h0200
`define UCQSC_FIFO_DEPTH_MAX 16'h0400
`endif

/* ucqsc_pkg.sv */
`default_nettype none
package ucqsc_pkg;
  typedef enum logic [1:0] {
    UCQSC_REQ_TOKEN = 2'h0,
    UCQSC_REQ_ZLP   = 2'h1,
    UCQSC_REQ_RSVD  = 2'h2,
    UCQSC_REQ_HALT  = 2'h3
  } ucqsc_req_t;
endpackage
`default_nettype wire

/* ucqsc_usb_core_queue_status_config.sv */
// Implementation choice: the strobed register port.
`include "ucqsc_defs.svh"
`default_nettype none
module ucqsc_usb_core_queue_status_config #(
  parameter logic [3:0]  QDEPTH      = 4'h8,
  parameter logic [15:0] FIFO_DEPTH  = `UCQSC_FIFO_DEPTH,
  parameter logic [31:0] CID_RESET   = `UCQSC_CID_RESET  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output var  logic [31:0] regRdata,
  // Core mode and pins
  input  wire logic        hostMode,
  input  wire logic        vbusPin,
  // Request queue push side (from host channels)
  input  wire logic        reqPush,
  input  wire logic [3:0]  reqChannel,
  input  wire ucqsc_pkg::ucqsc_req_t reqType,
  input  wire logic        reqLast,
  // Request queue consume side (from transmit engine)
  input  wire logic        reqPop,
  // FIFO word accounting
  input  wire logic        wordPush,
  input  wire logic        wordPop,
  // Configuration outputs and queue and FIFO full flags
  output var  logic        vbusValid,
  output var  logic        framePulseEnable,
  output var  logic        bSideComparatorEnable,
  output var  logic        aSideComparatorEnable,
  output var  logic        phyPowerOn,
  output var  logic        queueFull,
  output var  logic        fifoFull
);

  // Request queue storage, seven bits per entry
  logic [6:0]  queueMem [QDEPTH];
  logic [6:0]  queueMemD [QDEPTH];

  // Queue pointers
  logic [2:0]  rdPtr_q;
  logic [2:0]  rdPtr_d;
  logic [2:0]  wrPtr_q;
  logic [2:0]  wrPtr_d;

  // Free entry count
  logic [7:0]  qFree_q;
  logic [7:0]  qFree_d;

  // Free word count
  logic [15:0] fFree_q;
  logic [15:0] fFree_d;

  // Software visible registers
  logic [31:0] cfg_q;
  logic [31:0] cfg_d;
  logic [31:0] cid_q;
  logic [31:0] cid_d;
  logic [31:0] rdata_d;

  // Pin synchroniser
  logic        vbusMeta_q;
  logic        vbusSync_q;

  // Next values of the registered outputs
  logic        vbusValid_d;
  logic        framePulseEnable_d;
  logic        bSideComparatorEnable_d;
  logic        aSideComparatorEnable_d;
  logic        phyPowerOn_d;
  logic        queueFull_d;
  logic        fifoFull_d;

  // Accepted events and decodes
  logic        doPush;
  logic        doPop;
  logic        doWPush;
  logic        doWPop;
  logic        queueEmpty;
  logic        fifoEmpty;
  logic        wrCfg;
  logic        wrCid;

  // Status word assembly
  logic [6:0]  topEntry;
  logic [31:0] statusWord;

  // Next pointer position, wrapping at the queue depth
  function automatic logic [2:0] ptrNext(input logic [2:0] p);
    ptrNext = (p == 3'(QDEPTH - 4'h1)) ? 3'h0 : 3'(p + 3'h1);
  endfunction

  // Register select for one mapped word
  function automatic logic hitReg(input logic [7:0] a, input logic [7:0] off);
    hitReg = (a == off);
  endfunction

  // Free count after a take and a give; both in one cycle cancel out
  function automatic logic [15:0] countNext(input logic [15:0] c, input logic take, input logic give);
    countNext = c;
    if (take && !give) begin
      countNext = c - 16'h0001;
    end else if (give && !take) begin
      countNext = c + 16'h0001;
    end
  endfunction

  // Pushes refused when full, pops refused when empty; no push or pop is taken in device mode
  always_comb begin
    queueEmpty = (qFree_q == 8'(QDEPTH));
    fifoEmpty  = (fFree_q == FIFO_DEPTH);
    doPush     = hostMode && reqPush && (qFree_q != 8'h00);
    doPop      = hostMode && reqPop && !queueEmpty;
    doWPush    = hostMode && wordPush && (fFree_q != 16'h0000);
    doWPop     = hostMode && wordPop && !fifoEmpty;
    wrCfg      = regWr && hitReg(regAddr, `UCQSC_OFF_CFG);
    wrCid      = regWr && hitReg(regAddr, `UCQSC_OFF_CID);
  end

  // Queue entries and pointers
  always_comb begin
    queueMemD = queueMem;
    wrPtr_d   = wrPtr_q;
    rdPtr_d   = rdPtr_q;
    if (doPush) begin
      queueMemD[wrPtr_q] = {reqChannel, reqType, reqLast}; // [RULE3] [RULE4] [RULE5]
      wrPtr_d            = ptrNext(wrPtr_q);
    end
    if (doPop) begin
      rdPtr_d = ptrNext(rdPtr_q);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < int'(QDEPTH); i++) begin
        queueMem[i] <= 7'h00;
      end
      wrPtr_q <= 3'h0;
      rdPtr_q <= 3'h0;
    end else begin
      queueMem <= queueMemD;
      wrPtr_q  <= wrPtr_d;
      rdPtr_q  <= rdPtr_d;
    end
  end

  // Free entry count follows pushes and pops
  always_comb begin
    qFree_d = 8'(countNext({8'h00, qFree_q}, doPush, doPop)); // [RULE16] [RULE6]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qFree_q <= 8'(`UCQSC_QSTAT_RESET >> 16); // [RULE8]
    end else begin
      qFree_q <= qFree_d;
    end
  end

  // Free word count follows word pushes and pops
  always_comb begin
    fFree_d = countNext(fFree_q, doWPush, doWPop); // [RULE16] [RULE7]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fFree_q <= 16'(`UCQSC_QSTAT_RESET); // [RULE8]
    end else begin
      fFree_q <= fFree_d;
    end
  end

  // Configuration word; reserved bits always stay zero
  always_comb begin
    cfg_d = cfg_q;
    if (wrCfg) begin
      cfg_d = regWdata & `UCQSC_CFG_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= `UCQSC_CFG_RESET; // [RULE13]
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Identifier word, free for software use
  always_comb begin
    cid_d = cid_q;
    if (wrCid) begin
      cid_d = regWdata; // [RULE14]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cid_q <= CID_RESET;
    end else begin
      cid_q <= cid_d;
    end
  end

  // Read data; unmapped words and idle cycles read zero
  always_comb begin
    topEntry   = queueEmpty ? 7'h00 : queueMem[rdPtr_q]; // [RULE3]
    statusWord = {1'b0, topEntry, qFree_q, fFree_q}; // [RULE3] [RULE6] [RULE7]
    rdata_d    = 32'h0000_0000;
    if (regRd) begin
      if (hitReg(regAddr, `UCQSC_OFF_QSTAT)) begin
        // Device mode reads zero: contents are not valid there
        rdata_d = hostMode ? statusWord : 32'h0000_0000; // [RULE1]
      end else if (hitReg(regAddr, `UCQSC_OFF_CFG)) begin
        rdata_d = cfg_q;
      end else if (hitReg(regAddr, `UCQSC_OFF_CID)) begin
        rdata_d = cid_q; // [RULE14]
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata <= 32'h0000_0000;
    end else begin
      regRdata <= rdata_d;
    end
  end

  // Two flops before the pin level is used
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vbusMeta_q <= 1'b0;
      vbusSync_q <= 1'b0;
    end else begin
      vbusMeta_q <= vbusPin;
      vbusSync_q <= vbusMeta_q;
    end
  end

  // Outputs take next values, so they change at the same edge as the configuration and free count registers
  always_comb begin
    vbusValid_d             = cfg_d[`UCQSC_BIT_VBUSIGN] | vbusSync_q; // [RULE9]
    framePulseEnable_d      = cfg_d[`UCQSC_BIT_FRAMEOUT]; // [RULE10]
    bSideComparatorEnable_d = cfg_d[`UCQSC_BIT_BCOMP]; // [RULE11]
    aSideComparatorEnable_d = cfg_d[`UCQSC_BIT_ACOMP]; // [RULE11]
    phyPowerOn_d            = cfg_d[`UCQSC_BIT_PHYPWR]; // [RULE12]
    queueFull_d             = (qFree_d == 8'h00);
    fifoFull_d              = (fFree_d == 16'h0000);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vbusValid             <= 1'b0;
      framePulseEnable      <= 1'b0;
      bSideComparatorEnable <= 1'b0;
      aSideComparatorEnable <= 1'b0;
      phyPowerOn            <= 1'b0;
      queueFull             <= 1'b0;
      fifoFull              <= 1'b0;
    end else begin
      vbusValid             <= vbusValid_d;
      framePulseEnable      <= framePulseEnable_d;
      bSideComparatorEnable <= bSideComparatorEnable_d;
      aSideComparatorEnable <= aSideComparatorEnable_d;
      phyPowerOn            <= phyPowerOn_d;
      queueFull             <= queueFull_d;
      fifoFull              <= fifoFull_d;
    end
  end

endmodule
`default_nettype wire

/* ucqsc_checker.sv */
`default_nettype none
module ucqsc_checker #(
  parameter logic [15:0] FIFO_DEPTH = 16'h0200
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register port
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  // Mode and configuration outputs
  input wire logic        hostMode,
  input wire logic        framePulseEnable,
  input wire logic        phyPowerOn
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic rdStat;
  logic wrCfg;
  assign rdStat = regRd && regAddr == 8'h2C;
  assign wrCfg = regWr && regAddr == 8'h38;
  a_phy_power: assert property (wrCfg |=> phyPowerOn == $past(regWdata[16]))
    else $error("phy power bit not taken from write");
  a_frame_enable: assert property (wrCfg |=> framePulseEnable == $past(regWdata[20]))
    else $error("frame pulse enable not taken from write");
  a_cfg_hold: assert property (!wrCfg |=> $stable(phyPowerOn) && $stable(framePulseEnable))
    else $error("config output moved without a write");
  a_dev_zero: assert property (rdStat && !hostMode |=> regRdata == 32'h0)
    else $error("status not zero in device mode");
  a_top_type: assert property (rdStat |=> !regRdata[31] && regRdata[26:25] != 2'h2)
    else $error("top entry field malformed");
  a_queue_range: assert property (rdStat |=> regRdata[23:16] <= 8'h08)
    else $error("free entry count above eight");
  a_fifo_range: assert property (rdStat |=> regRdata[15:0] <= FIFO_DEPTH)
    else $error("free word count above depth");
  a_cfg_read: assert property (regRd && regAddr == 8'h38 |-> ##1 (regRdata & ~32'h003D_0000) == 32'h0
    && regRdata[16] == $past(phyPowerOn)) else $error("config read back wrong");
endmodule
`default_nettype wire

/* ucqsc_partner.sv */
`default_nettype none
module ucqsc_partner (
  // Bench control
  input  wire logic clk,
  input  wire logic go,
  input  wire logic slow,
  input  wire logic vbusOn,
  // Transmit engine side
  output var  logic reqPop,
  output var  logic wordPop,
  output var  logic vbusPin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pop = 1'b0;
  logic ph = 1'b0;
  // Slow mode consumes on every other cycle only
  always @(posedge clk) begin
    ph <= ~ph;
    pop <= go & (~slow | ph);
  end
  assign reqPop = pop;
  assign wordPop = pop;
  // Bus voltage as the bench sets it
  assign vbusPin = vbusOn;
endmodule
`default_nettype wire

/* test_usb_core_queue_status_config.sv */
`default_nettype none
module test_usb_core_queue_status_config;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] CID0 = 32'h1357_9BDF; // Arbitrary value
  logic        clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, hostMode = 1'b1, pend = 1'b0;
  logic        reqPush = 1'b0, reqLast = 1'b0, wordPush = 1'b0, go = 1'b0, slow = 1'b0, vbusOn = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [3:0]  reqChannel = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata, e;
  logic [1:0]  tt [3] = '{2'h0, 2'h1, 2'h3};
  logic        reqPop, wordPop, vbusPin, vbusValid, frameEn, bEn, aEn, phyOn, qFull, fFull;
  logic [31:0] expQ [$];
  int          n_fail = 0, n_checks = 0, cyc = 0, seed = 32'hFFD5;
  ucqsc_pkg::ucqsc_req_t reqType = ucqsc_pkg::UCQSC_REQ_TOKEN;
  ucqsc_usb_core_queue_status_config #(.CID_RESET(CID0)) i_dut (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .hostMode(hostMode),
    .vbusPin(vbusPin), .reqPush(reqPush), .reqChannel(reqChannel), .reqType(reqType), .reqLast(reqLast),
    .reqPop(reqPop), .wordPush(wordPush), .wordPop(wordPop), .vbusValid(vbusValid), .framePulseEnable(frameEn),
    .bSideComparatorEnable(bEn), .aSideComparatorEnable(aEn), .phyPowerOn(phyOn), .queueFull(qFull),
    .fifoFull(fFull));
  ucqsc_partner i_far (.clk(clk), .go(go), .slow(slow), .vbusOn(vbusOn), .reqPop(reqPop), .wordPop(wordPop),
    .vbusPin(vbusPin));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // A read notes its expected data for the watcher
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= w;
    regRd <= !w;
    if (!w) expQ.push_back(d);
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
  endtask
  function automatic logic [6:0] ent(input int i);
    return {4'(i + 1), tt[i % 3], i[0]};
  endfunction
  function automatic logic [31:0] st(input logic [6:0] t, input int q);
    return {1'b0, t, 8'(q), 16'(q)};
  endfunction
  always @(posedge clk) begin
    pend <= regRd;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      results();
    end
  end
  always @(negedge clk) if (pend) chk(regRdata, expQ.pop_front());
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    bus(0, 8'h2C, 32'h0008_0200);
    bus(0, 8'h38, 32'h0);
    bus(0, 8'h3C, CID0);
    bus(0, 8'h40, 32'h0);
    repeat (4) begin
      e = $random(seed);
      bus(1, 8'h38, e);
      bus(0, 8'h38, e & 32'h003D_0000);
      chk({vbusValid, frameEn, bEn, aEn, phyOn}, {e[21], e[20], e[19], e[18], e[16]});
      e = $random(seed);
      bus(1, 8'h3C, e);
      bus(0, 8'h3C, e);
    end
    bus(1, 8'h38, 32'h0);
    vbusOn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(vbusValid, 32'h1);
    vbusOn <= 1'b0;
    bus(1, 8'h2C, 32'hFFFF_FFFF);
    bus(0, 8'h2C, 32'h0008_0200);
    hostMode <= 1'b0;
    bus(0, 8'h2C, 32'h0);
    hostMode <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      reqPush <= 1'b1;
      reqChannel <= 4'(i + 1);
      reqType <= ucqsc_pkg::ucqsc_req_t'(tt[i % 3]);
      reqLast <= i[0];
    end
    @(posedge clk);
    reqPush <= 1'b0;
    wordPush <= 1'b1;
    repeat (513) @(posedge clk);
    wordPush <= 1'b0;
    bus(0, 8'h2C, st(ent(0), 0));
    chk({qFull, fFull}, 2'h3);
    for (int k = 1; k < 9; k++) begin
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      bus(0, 8'h2C, st(k < 8 ? ent(k) : 7'h00, k));
    end
    slow <= 1'b1;
    go <= 1'b1;
    repeat (1100) @(posedge clk);
    go <= 1'b0;
    bus(0, 8'h2C, 32'h0008_0200);
    results();
  end
endmodule
bind ucqsc_usb_core_queue_status_config ucqsc_checker #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (.clk(clk), .rst(rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .hostMode(hostMode), .framePulseEnable(framePulseEnable), .phyPowerOn(phyPowerOn));
`default_nettype wire
